// ===== design/awsf_map.svh
/*
 holds the address indexes, field masks, reset values and response codes
 of the alarm and warning shadow flag bank.
 assumes byte address = 4 * index on a 32-bit register bus.
*/
`ifndef AWSF_MAP_SVH
`define AWSF_MAP_SVH
`define AWSF_IDX_W 10
`define AWSF_IDX_ALM0 10'h0fb
`define AWSF_IDX_WRN3 10'h0fc
`define AWSF_IDX_WRN2 10'h0fd
`define AWSF_IDX_RSVA 10'h0fe
`define AWSF_IDX_RSVB 10'h0ff
`define AWSF_IDX_CTRL 10'h080
`define AWSF_MASK_ALM0 8'h08
`define AWSF_MASK_WRN3 8'hff
`define AWSF_MASK_WRN2 8'hf0
`define AWSF_BIT_BIAS 3
`define AWSF_BIT_SUPPLY_LO 4
`define AWSF_RST_FLAGS 8'h00
`define AWSF_RST_RSV 8'h00
`define AWSF_RST_CTRL 8'h1f
`define AWSF_RESP_OKAY 2'b00
`define AWSF_RESP_SLVERR 2'b10
`endif

// ===== design/awsf_pkg.sv
/*
 types shared by the shadow flag bank: register select and bus response.
 assumes awsf_map.svh for the numeric values.
*/
package awsf_pkg;
   typedef logic [1:0] awsf_resp_t;
   typedef enum logic [2:0] {
      AWSF_SEL_NONE = 3'b000,
      AWSF_SEL_ALM0 = 3'b001,
      AWSF_SEL_WRN3 = 3'b010,
      AWSF_SEL_WRN2 = 3'b011,
      AWSF_SEL_RSVA = 3'b100,
      AWSF_SEL_RSVB = 3'b101,
      AWSF_SEL_CTRL = 3'b110
   } awsf_sel_t;
endpackage

// ===== design/awsf_shadow_flags.sv
/*
 alarm and warning shadow flag bank with an AXI4-Lite slave.
 assumes event inputs and password grants come from logic on clock,
 and a master with at most one write and one read outstanding.
*/
// Function
// R1 - alarm-zero byte at FBh, resets 00h, only bit 3 bias ceiling flag
// R2 - alarm-zero byte uses same bit layout as lower byte 73h
// R3 - warning-three byte at FCh, eight temperature, supply and monitor flags
// R4 - supply low warning stays clear after power-on despite low supply
// R5 - warning-two byte at FDh, bits 7-4 monitor three/four, rest reserved
// R6 - flags latch; cleared by reset or level-one write; reads always allowed
// R7 - FEh and FFh reserved bytes, reset zero, write needs level one
// R8 - next table control byte resets 1Fh, read and write need level two
// R9 - event sets flag at once, stays set, beats a simultaneous clear
`timescale 1ns/1ps
`default_nettype none
`include "awsf_map.svh"
module awsf_shadow_flags #(
   parameter int ADDR_W = 12
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output awsf_pkg::awsf_resp_t bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output awsf_pkg::awsf_resp_t rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic password_level_one,
   input wire logic password_level_two,
   input wire logic bias_ceiling_event,
   input wire logic [7:0] warning_three_event,
   input wire logic [3:0] warning_two_event,
   output logic [7:0] bias_ceiling_alarm_latch,
   output logic [7:0] warning_group_three_latch,
   output logic [7:0] warning_group_two_latch,
   output logic [7:0] control_byte
);
   import awsf_pkg::*;

   function automatic awsf_sel_t decode(input logic [ADDR_W-1:0] addr);
      logic [`AWSF_IDX_W-1:0] idx;
      idx = addr[`AWSF_IDX_W+1:2];
      if (addr[1:0] != 2'b00) begin
         return AWSF_SEL_NONE;
      end
      unique case (idx)
         `AWSF_IDX_ALM0: return AWSF_SEL_ALM0;
         `AWSF_IDX_WRN3: return AWSF_SEL_WRN3;
         `AWSF_IDX_WRN2: return AWSF_SEL_WRN2;
         `AWSF_IDX_RSVA: return AWSF_SEL_RSVA;
         `AWSF_IDX_RSVB: return AWSF_SEL_RSVB;
         `AWSF_IDX_CTRL: return AWSF_SEL_CTRL;
         default: return AWSF_SEL_NONE;
      endcase
   endfunction

   // a write replaces the byte, then new events are or-ed on top
   function automatic logic [7:0] latch_next(
      input logic [7:0] old,
      input logic [7:0] ev,
      input logic wr,
      input logic [7:0] wbyte,
      input logic [7:0] mask
   );
      return ((wr ? wbyte : old) | ev) & mask;
   endfunction

   logic aw_have_reg;
   logic [ADDR_W-1:0] aw_addr_reg;
   logic w_have_reg;
   logic [7:0] w_byte_reg;
   logic w_lane_reg;
   logic bvalid_reg;
   awsf_resp_t bresp_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   awsf_resp_t rresp_reg;
   logic [7:0] alm0_reg;
   logic [7:0] wrn3_reg;
   logic [7:0] wrn2_reg;
   logic [7:0] rsva_reg;
   logic [7:0] rsvb_reg;
   logic [7:0] ctrl_reg;
   logic supply_arm_reg;

   // write channel: address and data captured in either order
   assign awready = !aw_have_reg && !bvalid_reg;
   assign wready = !w_have_reg && !bvalid_reg;
   wire aw_take = awvalid && awready;
   wire w_take = wvalid && wready;
   wire wr_fire = aw_have_reg && w_have_reg;
   wire awsf_sel_t wr_sel = decode(aw_addr_reg);
   wire pw1_ok = password_level_one || password_level_two;

   // R6 R7 R8 write gating by level
   wire wr_allowed = (wr_sel == AWSF_SEL_CTRL) ? password_level_two :
      (wr_sel != AWSF_SEL_NONE) && pw1_ok;
   wire wr_do = wr_fire && wr_allowed && w_lane_reg;
   wire wr_alm0 = wr_do && (wr_sel == AWSF_SEL_ALM0);
   wire wr_wrn3 = wr_do && (wr_sel == AWSF_SEL_WRN3);
   wire wr_wrn2 = wr_do && (wr_sel == AWSF_SEL_WRN2);
   wire wr_rsva = wr_do && (wr_sel == AWSF_SEL_RSVA);
   wire wr_rsvb = wr_do && (wr_sel == AWSF_SEL_RSVB);
   wire wr_ctrl = wr_do && (wr_sel == AWSF_SEL_CTRL);
   wire awsf_resp_t wr_resp = wr_allowed ? `AWSF_RESP_OKAY : `AWSF_RESP_SLVERR;

   // R4 supply low arm
   // the supply low event is ignored until it has been seen inactive once,
   // so a slow supply ramp at start-up never latches the flag
   wire supply_arm_next = supply_arm_reg || !warning_three_event[`AWSF_BIT_SUPPLY_LO];
   wire [7:0] wrn3_ev = supply_arm_reg ? warning_three_event :
      (warning_three_event & ~`AWSF_MASK_WRN3 | warning_three_event & 8'hef);

   // R1 R2 bias flag position
   wire [7:0] alm0_ev = {4'h0, bias_ceiling_event, 3'h0};
   // R5 monitor three and four in the upper nibble
   wire [7:0] wrn2_ev = {warning_two_event, 4'h0};

   // R6 R9 latch, set beats clear
   wire [7:0] alm0_next = latch_next(alm0_reg, alm0_ev, wr_alm0, w_byte_reg,
      `AWSF_MASK_ALM0);
   wire [7:0] wrn3_next = latch_next(wrn3_reg, wrn3_ev, wr_wrn3, w_byte_reg,
      `AWSF_MASK_WRN3);
   wire [7:0] wrn2_next = latch_next(wrn2_reg, wrn2_ev, wr_wrn2, w_byte_reg,
      `AWSF_MASK_WRN2);
   // R7 reserved bytes
   wire [7:0] rsva_next = wr_rsva ? w_byte_reg : rsva_reg;
   wire [7:0] rsvb_next = wr_rsvb ? w_byte_reg : rsvb_reg;
   // R8 control byte
   wire [7:0] ctrl_next = wr_ctrl ? w_byte_reg : ctrl_reg;

   // read channel: one read at a time, answered one cycle after the take
   assign arready = !rvalid_reg;
   wire ar_take = arvalid && arready;
   wire awsf_sel_t rd_sel = decode(araddr);
   // R8 control byte read needs level two
   wire rd_denied = (rd_sel == AWSF_SEL_NONE) ||
      ((rd_sel == AWSF_SEL_CTRL) && !password_level_two);
   // R6 flags readable at any level
   wire [7:0] rd_byte =
      (rd_sel == AWSF_SEL_ALM0) ? alm0_reg :
      (rd_sel == AWSF_SEL_WRN3) ? wrn3_reg :
      (rd_sel == AWSF_SEL_WRN2) ? wrn2_reg :
      (rd_sel == AWSF_SEL_RSVA) ? rsva_reg :
      (rd_sel == AWSF_SEL_RSVB) ? rsvb_reg :
      (rd_sel == AWSF_SEL_CTRL) ? ctrl_reg : 8'h00;
   wire [31:0] rd_word = rd_denied ? 32'h0000_0000 : {24'h00_0000, rd_byte};
   wire awsf_resp_t rd_resp = rd_denied ? `AWSF_RESP_SLVERR : `AWSF_RESP_OKAY;

   always_ff @(posedge clock) begin
      if (srst) begin
         aw_have_reg <= 1'b0;
         aw_addr_reg <= '0;
         w_have_reg <= 1'b0;
         w_byte_reg <= 8'h00;
         w_lane_reg <= 1'b0;
      end else begin
         aw_have_reg <= aw_take || (aw_have_reg && !wr_fire);
         w_have_reg <= w_take || (w_have_reg && !wr_fire);
         if (aw_take) begin
            aw_addr_reg <= awaddr;
         end
         if (w_take) begin
            w_byte_reg <= wdata[7:0];
            w_lane_reg <= wstrb[0];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= `AWSF_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= wr_resp;
      end else if (bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= `AWSF_RESP_OKAY;
      end else if (ar_take) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= rd_word;
         rresp_reg <= rd_resp;
      end else if (rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   // R1 R3 R5 R7 R8 power-on values
   always_ff @(posedge clock) begin
      if (srst) begin
         alm0_reg <= `AWSF_RST_FLAGS;
         wrn3_reg <= `AWSF_RST_FLAGS;
         wrn2_reg <= `AWSF_RST_FLAGS;
         rsva_reg <= `AWSF_RST_RSV;
         rsvb_reg <= `AWSF_RST_RSV;
         ctrl_reg <= `AWSF_RST_CTRL;
         supply_arm_reg <= 1'b0;
      end else begin
         alm0_reg <= alm0_next;
         wrn3_reg <= wrn3_next;
         wrn2_reg <= wrn2_next;
         rsva_reg <= rsva_next;
         rsvb_reg <= rsvb_next;
         ctrl_reg <= ctrl_next;
         supply_arm_reg <= supply_arm_next;
      end
   end

   assign bvalid = bvalid_reg;
   assign bresp = bresp_reg;
   assign rvalid = rvalid_reg;
   assign rdata = rdata_reg;
   assign rresp = rresp_reg;
   assign bias_ceiling_alarm_latch = alm0_reg;
   assign warning_group_three_latch = wrn3_reg;
   assign warning_group_two_latch = wrn2_reg;
   assign control_byte = ctrl_reg;

   default clocking @(posedge clock); endclocking
   default disable iff (srst);

   sequence s_read_alm0;
      ar_take && (rd_sel == AWSF_SEL_ALM0);
   endsequence

   sequence s_read_wrn3;
      ar_take && (rd_sel == AWSF_SEL_WRN3);
   endsequence

   sequence s_ctrl_peek;
      ar_take && (rd_sel == AWSF_SEL_CTRL) && !password_level_two;
   endsequence

   sequence s_blocked_rsva;
      wr_fire && (wr_sel == AWSF_SEL_RSVA) && !pw1_ok;
   endsequence

   alm0_layout_a: assert property ( // R1
      bias_ceiling_alarm_latch[7:4] == 4'h0 && bias_ceiling_alarm_latch[2:0] == 3'h0)
      else $error("reserved alarm-zero bits set");

   alm0_read_a: assert property ( // R2
      s_read_alm0 |=> rvalid && rdata[`AWSF_BIT_BIAS] == $past(alm0_reg[`AWSF_BIT_BIAS]))
      else $error("alarm-zero read lost the bias bit");

   wrn3_read_a: assert property ( // R3
      s_read_wrn3 |=> rvalid && rdata[7:0] == $past(wrn3_reg) && rresp == 2'b00)
      else $error("warning-three read mismatch");

   supply_quiet_a: assert property ( // R4
      !supply_arm_reg |-> !warning_group_three_latch[`AWSF_BIT_SUPPLY_LO])
      else $error("supply low flag set before arming");

   wrn2_low_a: assert property ( // R5
      warning_two_event[0] |=> warning_group_two_latch[4] && warning_group_two_latch[3:0] == 4'h0)
      else $error("warning-two layout wrong");

   flag_hold_a: assert property ( // R6
      alm0_reg[`AWSF_BIT_BIAS] && !wr_alm0 |=> alm0_reg[`AWSF_BIT_BIAS])
      else $error("bias flag dropped without a write");

   rsv_guard_a: assert property ( // R7
      s_blocked_rsva |=> $stable(rsva_reg) ##0 bresp == 2'b10 && bvalid)
      else $error("reserved byte written without level one");

   ctrl_guard_a: assert property ( // R8
      s_ctrl_peek |=> rvalid && rresp == 2'b10 && rdata == 32'h0)
      else $error("control byte read without level two");

   ctrl_reset_a: assert property ( // R8
      $fell(srst) |-> control_byte == 8'h1f && warning_group_three_latch == 8'h00)
      else $error("power-on values wrong");

   set_wins_a: assert property ( // R9
      bias_ceiling_event |=> bias_ceiling_alarm_latch[`AWSF_BIT_BIAS] [*1])
      else $error("bias event lost against a clear");

   sequence s_open_rsvb;
      wr_fire && (wr_sel == AWSF_SEL_RSVB) && pw1_ok && w_lane_reg;
   endsequence

   rsv_write_a: assert property ( // R7
      s_open_rsvb |=> rsvb_reg == $past(w_byte_reg))
      else $error("reserved byte missed a level-one write");

   wrn3_clear_a: assert property ( // R6
      wr_wrn3 && warning_three_event == 8'h00 |=> wrn3_reg == $past(w_byte_reg))
      else $error("warning-three write did not replace the byte");
endmodule
`default_nettype wire

// ===== verif/awsf_shadow_flags_bench.sv
/*
 self-checking bench for the shadow flag bank: AXI4-Lite master tasks,
 seeded random event and write traffic, corner cases around it.
 assumes awsf_map.svh on the include path and awsf_pkg compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "awsf_map.svh"
`define CHK(got, exp, msg) begin checks_done++; if ((got) !== (exp)) begin miscompares++; \
   $display("mismatch at %0t: %s", $time, msg); end end
module awsf_shadow_flags_bench;
   import awsf_pkg::*;
   logic clock = 0;
   logic srst = 1;
   logic [11:0] awaddr = 0;
   logic [11:0] araddr = 0;
   logic awvalid = 0;
   logic wvalid = 0;
   logic bready = 0;
   logic arvalid = 0;
   logic rready = 0;
   logic [31:0] wdata = 0;
   logic [3:0] wstrb = 0;
   logic password_level_one = 0;
   logic password_level_two = 0;
   logic bias_ceiling_event = 0;
   logic [7:0] warning_three_event = 8'h10;
   logic [3:0] warning_two_event = 0;
   logic awready, wready, bvalid, arready, rvalid;
   awsf_resp_t bresp, rresp, r;
   logic [31:0] rdata, d;
   logic [7:0] alm, wrn3, wrn2, control_byte, wd;
   logic [7:0] e [3];
   logic [7:0] m [3];
   logic p1, p2;
   logic [3:0] strb = 4'h1;
   int miscompares = 0;
   int checks_done = 0;
   int seed, i, k;
   always #4 clock = ~clock;
   awsf_shadow_flags #(.ADDR_W(12)) awsf_shadow_flags_inst (.clock(clock), .srst(srst),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .password_level_one(password_level_one),
      .password_level_two(password_level_two), .bias_ceiling_event(bias_ceiling_event),
      .warning_three_event(warning_three_event), .warning_two_event(warning_two_event),
      .bias_ceiling_alarm_latch(alm), .warning_group_three_latch(wrn3),
      .warning_group_two_latch(wrn2), .control_byte(control_byte));
   task automatic finish_test;
      $display("comparisons %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic guard(input int n);
      if (n >= 60) begin
         miscompares++;
         $display("mismatch at %0t: bus wait ran out", $time);
         finish_test();
      end
   endtask
   function automatic logic [11:0] ba(input logic [9:0] idx);
      return {idx, 2'b00};
   endfunction
   // write and read start one edge in, so no signal is assigned twice in a time step
   task automatic wr(input logic [11:0] a, input logic [7:0] v, output awsf_resp_t rs);
      int n;
      logic ad;
      logic dd;
      n = 0;
      ad = 0;
      dd = 0;
      @(posedge clock);
      awaddr <= a;
      wdata <= {24'h0, v};
      wstrb <= strb;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      while (!(ad && dd) && n < 60) begin
         @(posedge clock);
         n++;
         if (awvalid && awready) begin
            ad = 1;
            awvalid <= 0;
         end
         if (wvalid && wready) begin
            dd = 1;
            wvalid <= 0;
         end
      end
      while (bvalid !== 1'b1 && n < 60) begin
         @(posedge clock);
         n++;
      end
      guard(n);
      rs = bresp;
      bready <= 0;
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] v, output awsf_resp_t rs);
      int n;
      n = 0;
      @(posedge clock);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do begin
         @(posedge clock);
         n++;
      end while (!(arready === 1'b1) && n < 60);
      arvalid <= 0;
      while (rvalid !== 1'b1 && n < 60) begin
         @(posedge clock);
         n++;
      end
      guard(n);
      v = rdata;
      rs = rresp;
      rready <= 0;
   endtask
   task automatic chk_ports;
      `CHK(alm, e[0], "alarm-zero latch")
      `CHK(wrn3, e[1], "warning-three latch")
      `CHK(wrn2, e[2], "warning-two latch")
   endtask
   initial begin
      seed = 61058;
      m = '{`AWSF_MASK_ALM0, `AWSF_MASK_WRN3, `AWSF_MASK_WRN2};
      e = '{8'h00, 8'h00, 8'h00};
      repeat (10) @(posedge clock);
      srst <= 0;
      repeat (3) @(posedge clock);
      warning_three_event <= 0;
      #1;
      `CHK(wrn3, 8'h00, "supply low set at power-on")
      for (i = 'hfb; i <= 'hff; i++) begin
         rd(ba(i[9:0]), d, r);
         `CHK(d, 32'h0, "power-on value")
         `CHK(r, `AWSF_RESP_OKAY, "read at no level")
      end
      password_level_two <= 1;
      rd(ba(`AWSF_IDX_CTRL), d, r);
      `CHK(d, 32'h1f, "control power-on value")
      password_level_two <= 0;
      rd(ba(`AWSF_IDX_CTRL), d, r);
      `CHK({r, d}, {`AWSF_RESP_SLVERR, 32'h0}, "control read without level two")
      for (i = 0; i < 24; i++) begin
         bias_ceiling_event <= 1'($random(seed));
         warning_three_event <= 8'($random(seed));
         warning_two_event <= 4'($random(seed));
         @(posedge clock);
         e[0] = e[0] | (bias_ceiling_event ? 8'h08 : 8'h00);
         e[1] = e[1] | warning_three_event;
         e[2] = e[2] | {warning_two_event, 4'h0};
         bias_ceiling_event <= 0;
         warning_three_event <= 0;
         warning_two_event <= 0;
         k = $unsigned($random(seed)) % 3;
         wd = 8'($random(seed));
         p1 = 1'($random(seed));
         p2 = 1'($random(seed));
         password_level_one <= p1;
         password_level_two <= p2;
         @(posedge clock);
         #1;
         chk_ports();
         wr(ba(`AWSF_IDX_ALM0 + k[9:0]), wd, r);
         `CHK(r, (p1 | p2) ? `AWSF_RESP_OKAY : `AWSF_RESP_SLVERR, "flag write response")
         if (p1 | p2) begin
            e[k] = wd & m[k];
         end
         rd(ba(`AWSF_IDX_ALM0 + k[9:0]), d, r);
         `CHK({r, d}, {`AWSF_RESP_OKAY, 24'h0, e[k]}, "flag readback")
         chk_ports();
      end
      bias_ceiling_event <= 1;
      password_level_one <= 1;
      wr(ba(`AWSF_IDX_ALM0), 8'h00, r);
      bias_ceiling_event <= 0;
      @(posedge clock);
      #1;
      `CHK(alm, 8'h08, "clear lost to new event")
      wr(ba(`AWSF_IDX_ALM0), 8'h00, r);
      #1;
      `CHK(alm, 8'h00, "level-one clear")
      // level two left over from the random loop would also open these bytes
      @(posedge clock);
      password_level_two <= 0;
      for (i = 'hfe; i <= 'hff; i++) begin
         password_level_one <= 1;
         wr(ba(i[9:0]), 8'h5a, r);
         `CHK(r, `AWSF_RESP_OKAY, "reserved write with level one")
         password_level_one <= 0;
         wr(ba(i[9:0]), 8'ha5, r);
         `CHK(r, `AWSF_RESP_SLVERR, "reserved write without level")
         rd(ba(i[9:0]), d, r);
         `CHK({r, d}, {`AWSF_RESP_OKAY, 32'h5a}, "reserved byte readback")
      end
      password_level_one <= 1;
      strb = 4'h0;
      wr(ba(`AWSF_IDX_RSVA), 8'h00, r);
      strb = 4'h1;
      `CHK(r, `AWSF_RESP_OKAY, "write with byte lane off")
      rd(ba(`AWSF_IDX_RSVA), d, r);
      `CHK({r, d}, {`AWSF_RESP_OKAY, 32'h5a}, "byte lane off kept byte")
      wd = 8'($random(seed));
      password_level_two <= 1;
      wr(ba(`AWSF_IDX_CTRL), wd, r);
      #1;
      `CHK({r, control_byte}, {`AWSF_RESP_OKAY, wd}, "control write with level two")
      @(posedge clock);
      password_level_two <= 0;
      password_level_one <= 1;
      wr(ba(`AWSF_IDX_CTRL), ~wd, r);
      #1;
      `CHK({r, control_byte}, {`AWSF_RESP_SLVERR, wd}, "control write at level one")
      wr(12'h040, 8'hff, r);
      `CHK(r, `AWSF_RESP_SLVERR, "unmapped write")
      rd(12'h3ed, d, r);
      `CHK(r, `AWSF_RESP_SLVERR, "misaligned read")
      warning_two_event <= 4'hf;
      @(posedge clock);
      warning_two_event <= 0;
      srst <= 1;
      repeat (2) @(posedge clock);
      srst <= 0;
      #1;
      e = '{8'h00, 8'h00, 8'h00};
      chk_ports();
      `CHK(control_byte, `AWSF_RST_CTRL, "control after second reset")
      finish_test();
   end
endmodule
`default_nettype wire
